// [hw/ddrmr_burst_seq.sv]
// Column offset of one beat inside a wrapping burst block
// Assumes len_log2 is 1, 2 or 3 and beat is below the burst length
`timescale 1ns/1ps
module ddrmr_burst_seq (
  // Burst shape
  input wire logic [2:0] start,
  input wire logic [1:0] len_log2,
  input wire logic interleave,
  // Beat
  input wire logic [2:0] beat,
  output logic [2:0] elem
);

  logic [2:0] mask;
  logic [2:0] sum;
  logic [2:0] low;

  assign mask = 3'((4'h1 << len_log2) - 4'h1);
  assign sum = start + beat;
  assign low = interleave ? (start ^ beat) : sum;
  assign elem = (start & ~mask) | (low & mask);

endmodule // ddrmr_burst_seq

// [hw/ddrmr_delay_line.sv]
// Fixed-depth shift register carrying a read request to its launch cycle
// Assumes one request per cycle at most; no clock enable
`timescale 1ns/1ps
module ddrmr_delay_line #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage_q [DEPTH];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign dout = stage_q[DEPTH-1];

endmodule // ddrmr_delay_line

// [hw/ddrmr_params.svh]
// Constants for the mode register block: register offsets, field positions, reset values, counts
// Assumes inclusion by bare name from every design file that needs them
`ifndef DDRMR_PARAMS_SVH
`define DDRMR_PARAMS_SVH

// APB register offsets (byte addresses)
`define DDRMR_OFF_MODE 12'h000
`define DDRMR_OFF_EXT 12'h004
`define DDRMR_OFF_STATUS 12'h008
`define DDRMR_OFF_CTRL 12'h00c

// Mode register fields
`define DDRMR_MR_BL_MSB 2
`define DDRMR_MR_BL_LSB 0
`define DDRMR_MR_BT_BIT 3
`define DDRMR_MR_CL_MSB 6
`define DDRMR_MR_CL_LSB 4
`define DDRMR_MR_OP_MSB 12
`define DDRMR_MR_OP_LSB 7
`define DDRMR_MR_DLLRST_BIT 8
`define DDRMR_MR_RESET 13'h0000

// Latency, burst length and operating-mode encodings
`define DDRMR_CL_TWO 3'h2
`define DDRMR_CL_TWO_HALF 3'h6
`define DDRMR_BL_TWO 3'h1
`define DDRMR_BL_FOUR 3'h2
`define DDRMR_BL_EIGHT 3'h3
`define DDRMR_OP_NORMAL 6'h00
`define DDRMR_OP_DLL_RESET 6'h02
`define DDRMR_OP_MASK_SMALL 6'h1f
`define DDRMR_OP_MASK_LARGE 6'h3f

// Extended register fields
`define DDRMR_EMR_DLL_DIS_BIT 0
`define DDRMR_EMR_DRIVE_BIT 1
`define DDRMR_EMR_RESET 13'h0000

// Module sizes
`define DDRMR_SIZE_128 2'h0
`define DDRMR_SIZE_256 2'h1
`define DDRMR_SIZE_512 2'h2

// Status and control fields
`define DDRMR_ST_DLL_ON 0
`define DDRMR_ST_DLL_READY 1
`define DDRMR_ST_CL_VALID 2
`define DDRMR_ST_ERR_EARLY 8
`define DDRMR_ST_ERR_CL 9
`define DDRMR_ST_ERR_MODE 10
`define DDRMR_ST_ERR_SEL 11
`define DDRMR_CTRL_CMD_EN 0
`define DDRMR_CTRL_GUARD 1
`define DDRMR_CTRL_RESET 2'h1

// Timing counts in clock cycles
`define DDRMR_READ_LAT_CYCLES 2
`define DDRMR_DLL_LOCK_CYCLES 8'hc8

`endif

// [hw/ddrmr_pkg.sv]
// Types shared by the mode register block
// Assumes the constants header is included where numbers are needed
package ddrmr_pkg;

  typedef enum logic [1:0] {
    ddrmr_bidle = 2'b01,
    ddrmr_brun = 2'b10
  } ddrmr_bst_t;

  typedef enum logic [2:0] {
    ddrmr_lat_none = 3'b001,
    ddrmr_lat_two = 3'b010,
    ddrmr_lat_two_half = 3'b100
  } ddrmr_lat_t;

endpackage

// [hw/ddrmr_top.sv]
// Mode and extended-mode register logic of a DDR memory device, with read launch timing
// Assumes command pins synchronous to pclk, pclk standing for the memory clock, APB master
//
// Summary of operation
// - Read latency two or two-and-half clocks
// - First read data at edge n plus latency
// - Both bank selects zero address base register
// - Burst type bit picks sequential or interleaved
// - Low column bits give burst start element
// - Burst wraps in block, add or xor
// - Column top bit nine, eleven on largest
// - Zero operating-mode bits select normal operation
// - Bit eight alone starts DLL reset
// - DLL reset bit self-clears, others hold
// - Bank select low alone writes extended register
// - Extended register holds until reprogrammed
// - Self refresh exit enables DLL automatically
`timescale 1ns/1ps
`include "ddrmr_params.svh"
module ddrmr_top #(
  parameter logic [1:0] MODULE_SIZE = `DDRMR_SIZE_512
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic [12:0] addr,
  // Read launch
  output logic rd_beat_valid,
  output logic rd_half_cycle,
  output logic [10:0] rd_col_even,
  output logic [10:0] rd_col_odd,
  // DLL and drive state
  output logic dll_reset_pulse,
  output logic dll_on,
  output logic dll_ready,
  output logic drive_reduced
);

  logic [12:0] mr_q;
  logic [12:0] emr_q;
  logic [1:0] ctrl_q;
  logic [3:0] err_q;
  logic [3:0] err_set;
  logic [3:0] err_clr;
  logic dll_on_q;
  logic dll_reset_q;
  logic [7:0] lock_cnt_q;
  logic in_sref_q;
  logic [31:0] prdata_q;
  logic slverr_q;

  // Command decode
  logic cmd_sel;
  logic lmr_cmd;
  logic rd_cmd;
  logic sref_cmd;
  logic base_load;
  logic ext_load;
  logic bad_sel;
  logic [5:0] op_mask;
  logic [5:0] op_bits;
  logic op_normal;
  logic op_dll_reset;
  logic sr_exit;
  logic dll_enable_evt;
  ddrmr_pkg::ddrmr_lat_t lat;

  assign cmd_sel = ~cs_n & cke & ctrl_q[`DDRMR_CTRL_CMD_EN];
  assign lmr_cmd = cmd_sel & ~ras_n & ~cas_n & ~we_n;
  assign rd_cmd = cmd_sel & ras_n & ~cas_n & we_n;
  assign sref_cmd = ~cs_n & ~cke & ~ras_n & ~cas_n & we_n;
  assign base_load = lmr_cmd & ~bank_select_lo & ~bank_select_hi;
  assign ext_load = lmr_cmd & bank_select_lo & ~bank_select_hi;
  assign bad_sel = lmr_cmd & bank_select_hi;
  // The smallest module has no bit 12 in its operating-mode field
  assign op_mask = (MODULE_SIZE == `DDRMR_SIZE_128) ? `DDRMR_OP_MASK_SMALL :
                   `DDRMR_OP_MASK_LARGE;
  assign op_bits = addr[`DDRMR_MR_OP_MSB:`DDRMR_MR_OP_LSB] & op_mask;
  assign op_normal = (op_bits == `DDRMR_OP_NORMAL);
  assign op_dll_reset = (op_bits == `DDRMR_OP_DLL_RESET);
  assign sr_exit = in_sref_q & cke;
  assign dll_enable_evt = sr_exit | (base_load & op_dll_reset) |
                          (ext_load & ~addr[`DDRMR_EMR_DLL_DIS_BIT] & ~dll_on_q);

  always_comb begin
    case (mr_q[`DDRMR_MR_CL_MSB:`DDRMR_MR_CL_LSB])
      `DDRMR_CL_TWO: lat = ddrmr_pkg::ddrmr_lat_two;
      `DDRMR_CL_TWO_HALF: lat = ddrmr_pkg::ddrmr_lat_two_half;
      default: lat = ddrmr_pkg::ddrmr_lat_none;
    endcase
  end

  // Base mode register; reserved operating modes are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_q <= `DDRMR_MR_RESET;
    end else if (base_load && (op_normal || op_dll_reset)) begin
      mr_q <= addr & {op_mask, 7'h7f};
    end else begin
      mr_q[`DDRMR_MR_DLLRST_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_reset_q <= 1'b0;
    end else begin
      dll_reset_q <= base_load & op_dll_reset;
    end
  end

  // Extended register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emr_q <= `DDRMR_EMR_RESET;
    end else if (ext_load) begin
      emr_q <= addr;
    end
  end

  // Self refresh tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sref_q <= 1'b0;
    end else if (sref_cmd) begin
      in_sref_q <= 1'b1;
    end else if (cke) begin
      in_sref_q <= 1'b0;
    end
  end

  // DLL state kept apart from the extended register so self refresh exit leaves it intact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_on_q <= 1'b0;
    end else if (sr_exit) begin
      dll_on_q <= 1'b1;
    end else if (ext_load) begin
      dll_on_q <= ~addr[`DDRMR_EMR_DLL_DIS_BIT];
    end
  end

  // Lock wait: counts only clocks with cke high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_q <= 8'h00;
    end else if (dll_enable_evt || !dll_on_q) begin
      lock_cnt_q <= 8'h00;
    end else if (cke && lock_cnt_q != `DDRMR_DLL_LOCK_CYCLES) begin
      lock_cnt_q <= lock_cnt_q + 8'h01;
    end
  end

  logic lock_done;
  assign lock_done = dll_on_q && (lock_cnt_q == `DDRMR_DLL_LOCK_CYCLES);

  // Read launch path
  logic rd_go;
  logic [11:0] rd_in;
  logic [11:0] rd_out;
  logic [10:0] rd_col;

  // Column bits A0-A9, plus A11 on the largest module
  assign rd_col = (MODULE_SIZE == `DDRMR_SIZE_512) ? {addr[11], addr[9:0]} :
                  {1'b0, addr[9:0]};
  // Guarded reads are dropped so a controller slip is visible instead of corrupt data
  assign rd_go = rd_cmd && (lat != ddrmr_pkg::ddrmr_lat_none) &&
                 !(ctrl_q[`DDRMR_CTRL_GUARD] && !lock_done);
  assign rd_in = {rd_go, rd_col};

  ddrmr_delay_line #(
    .WIDTH(12),
    .DEPTH(`DDRMR_READ_LAT_CYCLES)
  ) u_lat (
    .pclk(pclk),
    .presetn(presetn),
    .din(rd_in),
    .dout(rd_out)
  );

  // Burst sequencing, two elements per clock
  ddrmr_pkg::ddrmr_bst_t bst_q;
  logic [10:0] start_q;
  logic [1:0] pair_q;
  logic launch;
  logic [10:0] seq_start;
  logic [1:0] seq_pair;
  logic [1:0] len_log2;
  logic [1:0] last_pair;
  logic [2:0] elem_even;
  logic [2:0] elem_odd;

  assign launch = rd_out[11];
  assign seq_start = launch ? rd_out[10:0] : start_q;
  assign seq_pair = launch ? 2'h0 : 2'(pair_q + 2'h1);

  always_comb begin
    case (mr_q[`DDRMR_MR_BL_MSB:`DDRMR_MR_BL_LSB])
      `DDRMR_BL_FOUR: len_log2 = 2'h2;
      `DDRMR_BL_EIGHT: len_log2 = 2'h3;
      default: len_log2 = 2'h1;
    endcase
  end
  // Four bits so a length of eight does not overflow the shift
  assign last_pair = 2'((4'h1 << len_log2) / 4'h2 - 4'h1);

  ddrmr_burst_seq u_seq_even (
    .start(seq_start[2:0]),
    .len_log2(len_log2),
    .interleave(mr_q[`DDRMR_MR_BT_BIT]),
    .beat({seq_pair, 1'b0}),
    .elem(elem_even)
  );

  ddrmr_burst_seq u_seq_odd (
    .start(seq_start[2:0]),
    .len_log2(len_log2),
    .interleave(mr_q[`DDRMR_MR_BT_BIT]),
    .beat({seq_pair, 1'b1}),
    .elem(elem_odd)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bst_q <= ddrmr_pkg::ddrmr_bidle;
      start_q <= 11'h000;
      pair_q <= 2'h0;
    end else begin
      case (bst_q)
        ddrmr_pkg::ddrmr_bidle, ddrmr_pkg::ddrmr_brun: begin
          if (launch) begin
            start_q <= rd_out[10:0];
            pair_q <= 2'h0;
            bst_q <= (last_pair != 2'h0) ? ddrmr_pkg::ddrmr_brun : ddrmr_pkg::ddrmr_bidle;
          end else if (bst_q == ddrmr_pkg::ddrmr_brun) begin
            pair_q <= seq_pair;
            if (seq_pair == last_pair) begin
              bst_q <= ddrmr_pkg::ddrmr_bidle;
            end
          end
        end
        default: bst_q <= ddrmr_pkg::ddrmr_bidle;
      endcase
    end
  end

  // Registered read outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_beat_valid <= 1'b0;
      rd_half_cycle <= 1'b0;
      rd_col_even <= 11'h000;
      rd_col_odd <= 11'h000;
    end else begin
      rd_beat_valid <= launch || (bst_q == ddrmr_pkg::ddrmr_brun);
      rd_half_cycle <= lat == ddrmr_pkg::ddrmr_lat_two_half;
      rd_col_even <= {seq_start[10:3], elem_even};
      rd_col_odd <= {seq_start[10:3], elem_odd};
    end
  end

  // Sticky error flags; a set in the clearing cycle wins
  assign err_set = {bad_sel,
                    base_load & ~op_normal & ~op_dll_reset,
                    rd_cmd & (lat == ddrmr_pkg::ddrmr_lat_none),
                    rd_cmd & ~lock_done};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 4'h0;
    end else begin
      err_q <= (err_q & ~err_clr) | err_set;
    end
  end

  // APB slave: read data captured in setup, zero-wait access phase
  logic apb_setup;
  logic apb_wr;
  logic mapped;

  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite & ~slverr_q;
  assign mapped = (paddr == `DDRMR_OFF_MODE) || (paddr == `DDRMR_OFF_EXT) ||
                  (paddr == `DDRMR_OFF_STATUS) || (paddr == `DDRMR_OFF_CTRL);
  assign err_clr = (apb_wr && paddr == `DDRMR_OFF_STATUS) ?
                   pwdata[`DDRMR_ST_ERR_SEL:`DDRMR_ST_ERR_EARLY] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (apb_setup) begin
      slverr_q <= ~mapped;
      case (paddr)
        `DDRMR_OFF_MODE: prdata_q <= {19'h0, mr_q};
        `DDRMR_OFF_EXT: prdata_q <= {19'h0, emr_q};
        `DDRMR_OFF_STATUS: prdata_q <= {20'h00000, err_q, 5'h00,
                                        lat != ddrmr_pkg::ddrmr_lat_none, lock_done, dll_on_q};
        `DDRMR_OFF_CTRL: prdata_q <= {30'h0, ctrl_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DDRMR_CTRL_RESET;
    end else if (apb_wr && paddr == `DDRMR_OFF_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & slverr_q;

  assign dll_reset_pulse = dll_reset_q;
  assign dll_on = dll_on_q;
  assign dll_ready = lock_done;
  assign drive_reduced = emr_q[`DDRMR_EMR_DRIVE_BIT];

  // Checks
  // Registered outputs set at edge n+2 are first seen by a sampling edge at n+3
  rd_lat_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_go |-> ##3 rd_beat_valid) else $error("read data not at latency edge");
  cl_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_go && lat == ddrmr_pkg::ddrmr_lat_two_half && !base_load |=> ##1 rd_half_cycle)
    else $error("half cycle flag missing");
  mode_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    base_load && op_normal |=> mr_q[6:0] == $past(addr[6:0]))
    else $error("base register not loaded");
  a8_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    mr_q[8] && !base_load |=> !mr_q[8]) else $error("dll reset bit stuck");
  dll_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    base_load && op_dll_reset |=> dll_reset_pulse ##1 !dll_reset_pulse || base_load)
    else $error("dll reset pulse wrong");
  ext_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_load |=> emr_q == $past(addr)) else $error("extended register not loaded");
  ext_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ext_load |=> $stable(emr_q)) else $error("extended register changed");
  sr_dll_a: assert property (@(posedge pclk) disable iff (!presetn)
    sr_exit |=> dll_on_q && !dll_ready) else $error("dll not on after self refresh");
  lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dll_ready) |-> $past(lock_cnt_q) == 8'hc7) else $error("lock wait wrong");
  wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_go && !mr_q[3] && mr_q[2:0] == 3'h2 && addr[1:0] == 2'h3 && !base_load
    |-> ##3 rd_col_odd[1:0] == 2'h0) else $error("sequential wrap wrong");

endmodule // ddrmr_top

// [tb/ddrmr_ctrl_model.sv]
// Memory controller model driving the command pins of the mode register block
// Assumes the bench calls its tasks from one process, one command at a time
`timescale 1ns/1ps
module ddrmr_ctrl_model (
  // Clock
  input wire logic pclk,
  // Command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_lo,
  output logic bank_select_hi,
  output logic [12:0] addr
);
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    ras_n = 1'b1;
    cas_n = 1'b1;
    we_n = 1'b1;
    bank_select_lo = 1'b0;
    bank_select_hi = 1'b0;
    addr = 13'h0000;
  end

  // One command for one clock; afterwards bank select and address pins show the inverse so stale values never match
  task automatic issue(input logic r, c, w, b1, b0, input logic [12:0] a, input logic k);
    @(posedge pclk);
    cs_n <= 1'b0;
    ras_n <= r;
    cas_n <= c;
    we_n <= w;
    bank_select_hi <= b1;
    bank_select_lo <= b0;
    addr <= a;
    cke <= k;
    @(posedge pclk);
    cs_n <= 1'b1;
    ras_n <= 1'b1;
    cas_n <= 1'b1;
    we_n <= 1'b1;
    bank_select_hi <= ~b1;
    bank_select_lo <= ~b0;
    addr <= ~a;
  endtask

  // Callers pick codes; only refusal scenarios pass reserved ones
  task automatic lmr(input logic b1, b0, input logic [12:0] a);
    issue(1'b0, 1'b0, 1'b0, b1, b0, a, 1'b1);
  endtask

  // Readiness wait is the caller's duty
  task automatic rd(input logic [12:0] a);
    issue(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, a, 1'b1);
  endtask

  task automatic sref();
    issue(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 13'h0000, 1'b0);
  endtask

  task automatic wake();
    @(posedge pclk);
    cke <= 1'b1;
  endtask
endmodule // ddrmr_ctrl_model

// [tb/ddrmr_top_test.sv]
// Self-checking bench for the mode register block: APB master tasks plus command model
// Assumes the default module size, so column bit 10 carries address bit 11
`timescale 1ns/1ps
`include "ddrmr_params.svh"
module ddrmr_top_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic e, cke, cs_n, ras_n, cas_n, we_n, bsl, bsh, rv, rh, rp, don, drdy, drv;
  logic [12:0] addr, a, mr;
  logic [10:0] ce, co;
  int bad_count, comparisons, i, bl, il, k;

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  ddrmr_ctrl_model ddrmr_ctrl_model_inst (.pclk(pclk), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_lo(bsl),
    .bank_select_hi(bsh), .addr(addr));

  ddrmr_top ddrmr_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select_lo(bsl), .bank_select_hi(bsh), .addr(addr), .rd_beat_valid(rv),
    .rd_half_cycle(rh), .rd_col_even(ce), .rd_col_odd(co), .dll_reset_pulse(rp),
    .dll_on(don), .dll_ready(drdy), .drive_reduced(drv));

  task automatic stop_test();
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic tmo();
    bad_count++;
    $display("Error %0t wait ran out", $time);
    stop_test();
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) tmo();
  endtask

  // Low bits wrap inside the block, block bits are kept
  function automatic logic [10:0] exp_col(input logic [10:0] b, input int lg, input logic il_f,
      input int beat);
    logic [2:0] m, s, x;
    m = 3'((1 << lg) - 1);
    s = b[2:0] & m;
    x = il_f ? (s ^ 3'(beat)) : ((s + 3'(beat)) & m);
    return (b & ~{8'h00, m}) | {8'h00, x};
  endfunction

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of all four words, then one unmapped word
    for (i = 0; i <= 16; i += 4) begin
      apb(1'b0, 12'(i), 32'h0);
      chk(d, (i == 12) ? 32'h1 : 32'h0);
      chk(32'(e), (i == 16) ? 32'h1 : 32'h0);
      chk(32'(pready), 32'h1);
    end
    ddrmr_ctrl_model_inst.lmr(1'b0, 1'b1, 13'h0002);
    @(posedge pclk);
    #1;
    chk(32'(drv), 32'h1);
    chk(32'(don), 32'h1);
    // High bank select must not touch either register
    ddrmr_ctrl_model_inst.lmr(1'b1, 1'b0, 13'h0001);
    apb(1'b0, `DDRMR_OFF_EXT, 32'h0);
    chk(d, 32'h2);
    apb(1'b0, `DDRMR_OFF_MODE, 32'h0);
    chk(d, 32'h0);
    ddrmr_ctrl_model_inst.lmr(1'b0, 1'b0, 13'h0122);
    // The pulse stands only in the cycle after the load edge
    #1;
    chk(32'(rp), 32'h1);
    @(posedge pclk);
    #1;
    chk(32'(rp), 32'h0);
    apb(1'b0, `DDRMR_OFF_MODE, 32'h0);
    chk(d, 32'h22);
    // A read before lock is flagged; the flag clears by writing one
    ddrmr_ctrl_model_inst.rd(13'h0000);
    apb(1'b0, `DDRMR_OFF_STATUS, 32'h0);
    chk(32'(d[8]), 32'h1);
    apb(1'b1, `DDRMR_OFF_STATUS, 32'h100);
    repeat (150) @(posedge pclk);
    #1;
    chk(32'(drdy), 32'h0);
    for (i = 0; i < 100 && drdy !== 1'b1; i++) @(posedge pclk);
    if (i >= 100) tmo();
    apb(1'b0, `DDRMR_OFF_STATUS, 32'h0);
    chk({23'h0, d[8:0]}, 32'h7);
    // Reserved operating mode is not stored
    ddrmr_ctrl_model_inst.lmr(1'b0, 1'b0, 13'h00a2);
    apb(1'b0, `DDRMR_OFF_MODE, 32'h0);
    chk(d, 32'h22);
    apb(1'b0, `DDRMR_OFF_STATUS, 32'h0);
    chk(32'(d[10]), 32'h1);
    chk(32'(d[11]), 32'h1);
    // Every length and order, both latencies, starts not on a block edge
    for (bl = 1; bl <= 3; bl++) begin
      for (il = 0; il <= 1; il++) begin
        mr = {6'h00, (il == 1) ? `DDRMR_CL_TWO_HALF : `DDRMR_CL_TWO, 1'(il), 3'(bl)};
        ddrmr_ctrl_model_inst.lmr(1'b0, 1'b0, mr);
        apb(1'b0, `DDRMR_OFF_MODE, 32'h0);
        chk(d, 32'(mr));
        // Odd starts; length four sequential starts at 7 to reach the wrap check
        a = 13'h0aa8 | 13'((bl * 4 + il * 2 + 7) & 7);
        ddrmr_ctrl_model_inst.rd(a);
        @(posedge pclk);
        for (k = 0; k < (1 << bl) / 2; k++) begin
          @(posedge pclk);
          #1;
          chk(32'(rv), 32'h1);
          chk(32'(rh), 32'(il));
          chk(32'(ce), 32'(exp_col({a[11], a[9:0]}, bl, 1'(il), 2 * k)));
          chk(32'(co), 32'(exp_col({a[11], a[9:0]}, bl, 1'(il), 2 * k + 1)));
        end
        @(posedge pclk);
        #1;
        chk(32'(rv), 32'h0);
      end
    end
    // Reserved latency code: the read is dropped
    ddrmr_ctrl_model_inst.lmr(1'b0, 1'b0, 13'h0012);
    ddrmr_ctrl_model_inst.rd(13'h0000);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      #1;
      chk(32'(rv), 32'h0);
    end
    apb(1'b0, `DDRMR_OFF_STATUS, 32'h0);
    chk(32'(d[9]), 32'h1);
    // DLL off, then self refresh exit turns it back on
    ddrmr_ctrl_model_inst.lmr(1'b0, 1'b1, 13'h0001);
    @(posedge pclk);
    #1;
    chk(32'(don), 32'h0);
    ddrmr_ctrl_model_inst.sref();
    repeat (3) @(posedge pclk);
    ddrmr_ctrl_model_inst.wake();
    for (i = 0; i < 4 && don !== 1'b1; i++) begin
      @(posedge pclk);
      #1;
    end
    chk(32'(don), 32'h1);
    chk(32'(drdy), 32'h0);
    // Guard on: a read before lock is dropped although the latency is valid
    ddrmr_ctrl_model_inst.lmr(1'b0, 1'b0, 13'h0022);
    apb(1'b1, `DDRMR_OFF_CTRL, 32'h3);
    ddrmr_ctrl_model_inst.rd(13'h0000);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      #1;
      chk(32'(rv), 32'h0);
    end
    stop_test();
  end
endmodule // ddrmr_top_test
